// *** rtl/fmul_cfg.svh ***
// Field positions, widths and constants of the multiply final add and exponent front end
`ifndef FMUL_CFG_SVH
`define FMUL_CFG_SVH

// Operand word layout
`define OPND_W 60
`define EXP_LO 48
`define EXP_HI 58
`define EXP_SIGN_BIT 59
`define COEF_TOP_BIT 47

// Exponent add network
`define EXP_W 11
`define EXP_SUM_W 13
`define EXP_BIAS_BIT 10
`define CORR_LO_BIT 4
`define CORR_HI_BIT 5
`define SP_THIRD_TERM 13'h0030

// Double-length product
`define UP_LO 24
`define UP_HI 95
`define LOW_W 24
`define RES_LO 48
`define SECT_W 8
`define SECT_N 9

`endif

// *** rtl/fmul_pkg.sv ***
// Types shared by the multiply final add and exponent front end
`include "fmul_cfg.svh"

package fmul_pkg;

	// Clock periods counted from instruction start; period one is START itself
	typedef enum logic [2:0] {
		PER_IDLE,
		PER_2,
		PER_3,
		PER_4,
		PER_5
	} period_t;

	// Three rows of the upper product entering the last reduction pass
	typedef struct packed {
		logic [`UP_HI-`UP_LO:0] row_a;
		logic [`UP_HI-`UP_LO:0] row_b;
		logic [`UP_HI-`UP_LO:0] row_c;
	} prod_rows_t;

	// Loop bits of the low product bits
	typedef struct packed {
		logic [`LOW_W-1:0] sum;
		logic [`LOW_W-1:0] carry;
	} low_loop_t;

	// Exponent add network pseudo sums and carries
	typedef struct packed {
		logic [`EXP_SUM_W-1:0] psum;
		logic [`EXP_SUM_W-1:0] pcar;
	} exp_net_t;

	// Section carries and enables of the coefficient final add
	typedef struct packed {
		logic [`SECT_N-1:0] carry;
		logic [`SECT_N-1:0] enable;
	} sect_t;

endpackage

// *** rtl/section_carry.sv ***
// Section carry and enable network with per-bit carry resolution
`timescale 1ns/10ps
`default_nettype none

module section_carry #(
	parameter int SECT_N = 9,
	parameter int SECT_W = 8
) (
	// Bit enables and bit generates
	input wire logic [SECT_N*SECT_W-1:0] bit_en,
	input wire logic [SECT_N*SECT_W-1:0] bit_gen,
	input wire logic carry_in,
	// Section terms and resolved carries
	output logic [SECT_N-1:0] sect_gen,
	output logic [SECT_N-1:0] sect_en,
	output logic [SECT_N*SECT_W-1:0] bit_carry
);

	logic [SECT_N:0] sect_cin;

	// Carry into the lowest section
	assign sect_cin[0] = carry_in;

	genvar gi;
	generate
		for (gi = 0; gi < SECT_N; gi++) begin : g_sect
			logic [SECT_W-1:0] car;
			logic gs;
			logic ps;

			// Section generate and enable, then carry pass and check inside the section
			always_comb begin
				logic c;
				c = sect_cin[gi];
				gs = 1'b0;
				ps = 1'b1;
				car = '0;
				for (int b = 0; b < SECT_W; b++) begin
					car[b] = c;
					c = bit_gen[gi*SECT_W+b] | (bit_en[gi*SECT_W+b] & c);
					gs = bit_gen[gi*SECT_W+b] | (bit_en[gi*SECT_W+b] & gs);
					ps = ps & bit_en[gi*SECT_W+b];
				end
			end

			// Section outputs and carry into the next section
			assign sect_gen[gi] = gs;
			assign sect_en[gi] = ps;
			assign sect_cin[gi+1] = gs | (ps & sect_cin[gi]);
			assign bit_carry[gi*SECT_W +: SECT_W] = car;
		end
	endgenerate

endmodule

`default_nettype wire

// *** rtl/float_multiply_final_add_exponent.sv ***
// Multiply final reduction, final add, normalize decision and exponent front end
// Function
// - Period four reduces upper product to two rows
// - Final add split: enables/carries, then propagation
// - Low bits 0-23 summed in period four
// - Enables 24-31 are XOR, registered for five
// - Carries 25-31 are AND in period four
// - Enables 32-95 are XOR, registered for five
// - Carries 33-95 are AND in period four
// - Period five forms eight-bit section carry/enable
// - Unnormalized operands force the top section carry
// - Complemented sum 48-95 recomplemented when gated out
// - Bit 95 zero means shift left one unless forced
// - Period one captures exponent, complement when negative
// - Complement exponent bits 0-9, bit 10 kept
// - Exponents added as 13-bit ones complement
// - Third term zero for double, 060 single
// - Pseudo sums 0-3, 6-10 are XNOR
// - Pseudo sums 4-5 include the precision adjust
// - Pseudo carries OR; 5, 6 include correction
// - Sum bit is enable XOR resolved carry
// - Precision adjust set in period one, immediately
`timescale 1ns/10ps
`default_nettype none
`include "fmul_cfg.svh"

module float_multiply_final_add_exponent (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	// Instruction start and operands
	input wire logic START,
	input wire logic DBL_PREC,
	input wire logic [`OPND_W-1:0] OPND_J,
	input wire logic [`OPND_W-1:0] OPND_K,
	// Product terms from the earlier reduction levels
	input wire fmul_pkg::prod_rows_t PROD_ROWS,
	input wire fmul_pkg::low_loop_t LOW_LOOP,
	// Coefficient results
	output logic [`LOW_W-1:0] PRODUCT_LOW,
	output logic [`UP_HI-`RES_LO:0] COEF_RESULT,
	output logic LEFT_SHIFT,
	output logic RESULT_VALID,
	output fmul_pkg::sect_t SECTIONS,
	output logic BUSY,
	// Exponent front end
	output logic PRECISION_ADJUST,
	output logic SIGN_J,
	output logic SIGN_K,
	output logic [`EXP_W-1:0] EXP_TRUE_J,
	output logic [`EXP_W-1:0] EXP_TRUE_K,
	output fmul_pkg::exp_net_t EXP_NET,
	output logic [`EXP_SUM_W-1:0] EXP_SUM
);

	localparam int UW = `UP_HI - `UP_LO + 1;
	localparam int RW = `UP_HI - `RES_LO + 1;
	localparam int RS = `RES_LO - `UP_LO;

	fmul_pkg::period_t st_q, st_d;
	logic start_ok;

	// Period one is the START cycle while idle; operands held by the caller after it
	assign start_ok = START && (st_q == fmul_pkg::PER_IDLE);

	// Period sequencer
	always_comb begin
		case (st_q)
			fmul_pkg::PER_IDLE: st_d = start_ok ? fmul_pkg::PER_2 : fmul_pkg::PER_IDLE;
			fmul_pkg::PER_2: st_d = fmul_pkg::PER_3;
			fmul_pkg::PER_3: st_d = fmul_pkg::PER_4;
			fmul_pkg::PER_4: st_d = fmul_pkg::PER_5;
			fmul_pkg::PER_5: st_d = fmul_pkg::PER_IDLE;
			default: st_d = fmul_pkg::PER_IDLE;
		endcase
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			st_q <= fmul_pkg::PER_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	assign BUSY = (st_q != fmul_pkg::PER_IDLE);

	// Exponent input registers and precision flag
	logic [`EXP_W-1:0] exp_j_q, exp_j_d, exp_k_q, exp_k_d;
	logic sign_j_q, sign_j_d, sign_k_q, sign_k_d;
	logic adj_q, adj_d;

	always_comb begin
		exp_j_d = exp_j_q;
		exp_k_d = exp_k_q;
		sign_j_d = sign_j_q;
		sign_k_d = sign_k_q;
		adj_d = adj_q;
		if (start_ok) begin
			exp_j_d = OPND_J[`EXP_SIGN_BIT] ? ~OPND_J[`EXP_HI:`EXP_LO] : OPND_J[`EXP_HI:`EXP_LO];
			exp_k_d = OPND_K[`EXP_SIGN_BIT] ? ~OPND_K[`EXP_HI:`EXP_LO] : OPND_K[`EXP_HI:`EXP_LO];
			sign_j_d = OPND_J[`EXP_SIGN_BIT];
			sign_k_d = OPND_K[`EXP_SIGN_BIT];
			adj_d = !DBL_PREC;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			exp_j_q <= '0;
			exp_k_q <= '0;
			sign_j_q <= 1'b0;
			sign_k_q <= 1'b0;
			adj_q <= 1'b0;
		end else begin
			exp_j_q <= exp_j_d;
			exp_k_q <= exp_k_d;
			sign_j_q <= sign_j_d;
			sign_k_q <= sign_k_d;
			adj_q <= adj_d;
		end
	end

	// Adjust reaches the output in the same cycle it is decided; the add network takes the registered copy
	assign PRECISION_ADJUST = start_ok ? !DBL_PREC : adj_q;
	assign SIGN_J = sign_j_q;
	assign SIGN_K = sign_k_q;
	assign EXP_TRUE_J = exp_j_q;
	assign EXP_TRUE_K = exp_k_q;

	// Add network inputs: low ten bits complemented, bias bit passed true
	logic [`EXP_W-1:0] add_j, add_k;
	assign add_j = {exp_j_q[`EXP_BIAS_BIT], ~exp_j_q[`EXP_BIAS_BIT-1:0]};
	assign add_k = {exp_k_q[`EXP_BIAS_BIT], ~exp_k_q[`EXP_BIAS_BIT-1:0]};

	// Add network first half and full ones complement sum
	fmul_pkg::exp_net_t net_q, net_d;
	logic [`EXP_SUM_W-1:0] esum_q, esum_d;
	logic [`EXP_SUM_W-1:0] third;
	logic [`EXP_SUM_W+1:0] raw;
	logic [`EXP_SUM_W:0] fold;

	always_comb begin
		net_d = net_q;
		esum_d = esum_q;
		third = adj_q ? `SP_THIRD_TERM : '0;
		raw = (`EXP_SUM_W+2)'(add_j) + (`EXP_SUM_W+2)'(add_k) + (`EXP_SUM_W+2)'(third);
		fold = (`EXP_SUM_W+1)'(raw[`EXP_SUM_W-1:0]) + (`EXP_SUM_W+1)'(raw[`EXP_SUM_W+1:`EXP_SUM_W]);
		if (st_q == fmul_pkg::PER_2) begin
			net_d = '0;
			for (int i = 0; i < `EXP_W; i++) begin
				if (i == `CORR_LO_BIT || i == `CORR_HI_BIT) begin
					net_d.psum[i] = add_j[i] ^ add_k[i] ^ adj_q;
				end else begin
					net_d.psum[i] = ~(add_j[i] ^ add_k[i]);
				end
				if (i == `CORR_LO_BIT || i == `CORR_HI_BIT) begin
					net_d.pcar[i+1] = add_j[i] | add_k[i] | adj_q;
				end else begin
					net_d.pcar[i+1] = add_j[i] | add_k[i];
				end
			end
			esum_d = fold[`EXP_SUM_W-1:0] + `EXP_SUM_W'(fold[`EXP_SUM_W]);
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			net_q <= '0;
			esum_q <= '0;
		end else begin
			net_q <= net_d;
			esum_q <= esum_d;
		end
	end

	assign EXP_NET = net_q;
	assign EXP_SUM = esum_q;

	// Last reduction pass: three rows to a pseudo sum and carry per position
	logic [UW-1:0] s_w, cr_w, en_w, gen_w;
	logic [`LOW_W:0] low_w;

	always_comb begin
		s_w = PROD_ROWS.row_a ^ PROD_ROWS.row_b ^ PROD_ROWS.row_c;
		cr_w = {(PROD_ROWS.row_a[UW-2:0] & PROD_ROWS.row_b[UW-2:0])
			| (PROD_ROWS.row_a[UW-2:0] & PROD_ROWS.row_c[UW-2:0])
			| (PROD_ROWS.row_b[UW-2:0] & PROD_ROWS.row_c[UW-2:0]), 1'b0};
		en_w = s_w ^ cr_w;
		gen_w = s_w & cr_w;
		low_w = (`LOW_W+1)'(LOW_LOOP.sum) + (`LOW_W+1)'(LOW_LOOP.carry);
	end

	// First half results held into period five
	logic [UW-1:0] en_q, en_d, bc_q, bc_d;
	logic force_q, force_d;
	logic [`LOW_W-1:0] plow_q, plow_d;

	always_comb begin
		en_d = en_q;
		bc_d = bc_q;
		force_d = force_q;
		plow_d = plow_q;
		if (st_q == fmul_pkg::PER_4) begin
			en_d = en_w;
			bc_d = {gen_w[UW-2:0], low_w[`LOW_W]};
			force_d = ~(OPND_J[`COEF_TOP_BIT] & OPND_K[`COEF_TOP_BIT]);
			plow_d = low_w[`LOW_W-1:0];
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			en_q <= '0;
			bc_q <= '0;
			force_q <= 1'b0;
			plow_q <= '0;
		end else begin
			en_q <= en_d;
			bc_q <= bc_d;
			force_q <= force_d;
			plow_q <= plow_d;
		end
	end

	assign PRODUCT_LOW = plow_q;

	// Second half: section terms and pass and carry check propagation
	logic [`SECT_N-1:0] sgen_w, sen_w;
	logic [UW-1:0] car_w, sum_n_w, true_w;

	section_carry #(
		.SECT_N(`SECT_N),
		.SECT_W(`SECT_W)
	) u_sect (
		.bit_en(en_q),
		.bit_gen({1'b0, bc_q[UW-1:1]}),
		.carry_in(bc_q[0]),
		.sect_gen(sgen_w),
		.sect_en(sen_w),
		.bit_carry(car_w)
	);

	// Sum in complemented form, recomplemented at the gate
	assign sum_n_w = ~(en_q ^ car_w);
	assign true_w = ~sum_n_w;

	// Result gating in period five with the normalizing shift decision
	logic [RW-1:0] coef_q, coef_d;
	logic shift_q, shift_d, valid_q, valid_d, norm_w;
	fmul_pkg::sect_t sect_q, sect_d;

	always_comb begin
		norm_w = true_w[UW-1] | force_q;
		coef_d = coef_q;
		shift_d = shift_q;
		sect_d = sect_q;
		valid_d = (st_q == fmul_pkg::PER_5);
		if (st_q == fmul_pkg::PER_5) begin
			shift_d = ~norm_w;
			coef_d = norm_w ? true_w[UW-1:RS] : true_w[UW-2:RS-1];
			sect_d.carry = sgen_w | {force_q, {(`SECT_N-1){1'b0}}};
			sect_d.enable = sen_w;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			coef_q <= '0;
			shift_q <= 1'b0;
			sect_q <= '0;
			valid_q <= 1'b0;
		end else begin
			coef_q <= coef_d;
			shift_q <= shift_d;
			sect_q <= sect_d;
			valid_q <= valid_d;
		end
	end

	assign COEF_RESULT = coef_q;
	assign LEFT_SHIFT = shift_q;
	assign SECTIONS = sect_q;
	assign RESULT_VALID = valid_q;

	// Checks on sequencing, datapath and exponent front end
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);

	property p_sequence;
		start_ok |=> st_q == fmul_pkg::PER_2 ##1 st_q == fmul_pkg::PER_3
			##1 st_q == fmul_pkg::PER_4 ##1 st_q == fmul_pkg::PER_5;
	endproperty
	a_sequence: assert property (p_sequence) else $error("period sequence broken");

	property p_valid;
		start_ok |=> !RESULT_VALID [*4] ##1 RESULT_VALID ##1 !RESULT_VALID; // Previous pulse may meet START
	endproperty
	a_valid: assert property (p_valid) else $error("result not gated after period five");

	property p_low;
		st_q == fmul_pkg::PER_4 |=> PRODUCT_LOW == $past(LOW_LOOP.sum + LOW_LOOP.carry);
	endproperty
	a_low: assert property (p_low) else $error("low product bits wrong");

	property p_enable24;
		st_q == fmul_pkg::PER_4 |=> en_q[0] == $past(PROD_ROWS.row_a[0] ^ PROD_ROWS.row_b[0]
			^ PROD_ROWS.row_c[0]);
	endproperty
	a_enable24: assert property (p_enable24) else $error("bit 24 enable wrong");

	property p_carry25;
		st_q == fmul_pkg::PER_4 |=> bc_q[2] == $past((PROD_ROWS.row_a[1] ^ PROD_ROWS.row_b[1]
			^ PROD_ROWS.row_c[1]) & (PROD_ROWS.row_a[0] & PROD_ROWS.row_b[0]
			| PROD_ROWS.row_a[0] & PROD_ROWS.row_c[0]
			| PROD_ROWS.row_b[0] & PROD_ROWS.row_c[0]));
	endproperty
	a_carry25: assert property (p_carry25) else $error("bit 25 carry wrong");

	property p_force;
		RESULT_VALID && $past(force_q) |-> !LEFT_SHIFT && SECTIONS.carry[`SECT_N-1];
	endproperty
	a_force: assert property (p_force) else $error("forced top carry missing");

	property p_shift;
		RESULT_VALID |-> LEFT_SHIFT == !$past(true_w[UW-1] | force_q);
	endproperty
	a_shift: assert property (p_shift) else $error("shift decision wrong");

	property p_coef;
		RESULT_VALID && !LEFT_SHIFT |-> COEF_RESULT == $past(true_w[UW-1:RS]);
	endproperty
	a_coef: assert property (p_coef) else $error("unshifted result wrong");

	property p_exp_true;
		start_ok && OPND_J[`EXP_SIGN_BIT] |=> EXP_TRUE_J == ~$past(OPND_J[`EXP_HI:`EXP_LO]);
	endproperty
	a_exp_true: assert property (p_exp_true) else $error("negative exponent not complemented");

	property p_prec;
		start_ok |-> PRECISION_ADJUST == !DBL_PREC ##1 PRECISION_ADJUST == !$past(DBL_PREC);
	endproperty
	a_prec: assert property (p_prec) else $error("precision adjust wrong");

	property p_psum0;
		st_q == fmul_pkg::PER_2 |=> EXP_NET.psum[0] == $past(exp_j_q[0] ~^ exp_k_q[0]);
	endproperty
	a_psum0: assert property (p_psum0) else $error("exponent pseudo sum 0 wrong");

	c_shift: cover property (RESULT_VALID && LEFT_SHIFT);
	c_noshift: cover property (RESULT_VALID && !LEFT_SHIFT);
	c_forced: cover property (RESULT_VALID && SECTIONS.carry[`SECT_N-1]);
	c_single: cover property (start_ok && !DBL_PREC);

endmodule

`default_nettype wire

// *** sim/operand_source.sv ***
// Partner model: operand and precision source that holds them for one instruction
`timescale 1ns/10ps
`default_nettype none

module operand_source (
	// Clock, reset and requests from the bench
	input wire logic clk,
	input wire logic rst,
	input wire logic go,
	input wire logic stray,
	input wire logic dbl,
	input wire logic [59:0] j,
	input wire logic [59:0] k,
	input wire logic done,
	// Drive towards the multiply unit
	output logic start,
	output logic dbl_prec,
	output logic [59:0] opnd_j,
	output logic [59:0] opnd_k
);
	logic start_q;
	logic hold_q;

	// Launch on the falling edge, hold until the result is gated, then scramble
	always @(negedge clk or posedge rst) begin
		if (rst) begin
			start_q <= 1'h0;
			hold_q <= 1'h0;
			dbl_prec <= 1'h0;
			opnd_j <= '0;
			opnd_k <= '0;
		end else begin
			start_q <= 1'h0;
			if (go && (!hold_q || done)) begin
				start_q <= 1'h1;
				hold_q <= 1'h1;
				dbl_prec <= dbl;
				opnd_j <= j;
				opnd_k <= k;
			end else if (done) begin
				hold_q <= 1'h0;
				dbl_prec <= ~dbl_prec;
				opnd_j <= ~opnd_j;
				opnd_k <= ~opnd_k;
			end
		end
	end

	// Stray starts let the bench probe the busy lockout
	assign start = start_q | stray;
endmodule
`default_nettype wire

// *** sim/test_float_multiply_final_add_exponent.sv ***
// Testbench for the multiply final add and exponent front end
`timescale 1ns/10ps
`default_nettype none

module test_float_multiply_final_add_exponent;
	logic sys_clk, rst, start, dbl_prec, go, stray, dblin, nd, linked;
	logic [59:0] opnd_j, opnd_k, jin, kin, nj, nk;
	fmul_pkg::prod_rows_t rows;
	fmul_pkg::low_loop_t low;
	logic [23:0] product_low;
	logic [47:0] coef;
	logic left_shift, rv, busy, padj, sign_j, sign_k;
	fmul_pkg::sect_t sections;
	logic [10:0] etj, etk;
	fmul_pkg::exp_net_t enet;
	logic [12:0] esum;
	int err_count = 0;
	int tests_run = 0;
	int cyc = 0;

	// Far side source of operands and precision
	operand_source source (.clk(sys_clk), .rst(rst), .go(go), .stray(stray), .dbl(dblin),
		.j(jin), .k(kin), .done(rv), .start(start), .dbl_prec(dbl_prec), .opnd_j(opnd_j),
		.opnd_k(opnd_k));

	float_multiply_final_add_exponent DUT (.SYS_CLK(sys_clk), .RST(rst), .START(start),
		.DBL_PREC(dbl_prec), .OPND_J(opnd_j), .OPND_K(opnd_k), .PROD_ROWS(rows),
		.LOW_LOOP(low), .PRODUCT_LOW(product_low), .COEF_RESULT(coef),
		.LEFT_SHIFT(left_shift), .RESULT_VALID(rv), .SECTIONS(sections), .BUSY(busy),
		.PRECISION_ADJUST(padj), .SIGN_J(sign_j), .SIGN_K(sign_k), .EXP_TRUE_J(etj),
		.EXP_TRUE_K(etk), .EXP_NET(enet), .EXP_SUM(esum));

	// Clock at 200 MHz
	initial begin
		sys_clk = 1'h0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// Cut a hang short
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 500) begin
			err_count++;
			give_verdict;
		end
	end

	task give_verdict;
		if (err_count == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Compare one result and count it
	task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask

	// Exponent as it enters the add network: true value, bits 9..0 inverted
	function automatic logic [12:0] add_in(input logic [59:0] o);
		logic [10:0] e;
		e = o[59] ? ~o[58:48] : o[58:48];
		return {2'h0, e[10], ~e[9:0]};
	endfunction

	// Ask the source for an instruction
	task automatic launch(input logic [59:0] j, input logic [59:0] k, input logic d);
		@(negedge sys_clk);
		jin <= j;
		kin <= k;
		dblin <= d;
		go <= 1'h1;
	endtask

	// Follow one instruction from its start cycle and check every result
	task automatic run(input logic [59:0] j, input logic [59:0] k, input logic d,
		input fmul_pkg::prod_rows_t r, input fmul_pkg::low_loop_t l, input logic chain,
		input logic str);
		logic [12:0] a, b, ps, pc;
		logic [71:0] s, m, e, g;
		logic [95:0] p;
		logic [8:0] sc, se;
		logic [24:0] lo;
		logic adj, f, gg;
		int t;
		a = add_in(j);
		b = add_in(k);
		adj = !d;
		t = a + b + (d ? 0 : 13'h0030);
		while (t >> 13) t = (t & 'h1FFF) + (t >> 13);
		ps = '0;
		pc = '0;
		for (int i = 0; i < 11; i++) begin
			ps[i] = (i == 4 || i == 5) ? a[i] ^ b[i] ^ adj : a[i] ~^ b[i];
			pc[i + 1] = a[i] | b[i] | ((i == 4 || i == 5) && adj);
		end
		lo = l.sum + l.carry;
		s = r.row_a ^ r.row_b ^ r.row_c;
		m = (r.row_a & r.row_b | r.row_a & r.row_c | r.row_b & r.row_c) << 1;
		e = s ^ m;
		g = s & m;
		g[71] = 1'h0; // Carry out of bit 95 is dropped
		p = {s + m + lo[24], lo[23:0]};
		f = !(j[47] & k[47]);
		for (int i = 0; i < 9; i++) begin
			gg = 1'h0;
			for (int q = 0; q < 8; q++) gg = g[8 * i + q] | e[8 * i + q] & gg;
			sc[i] = gg;
			se[i] = &e[8 * i +: 8];
		end
		sc[8] = sc[8] | f;
		if (!linked) begin
			@(negedge sys_clk);
			go <= 1'h0;
			#1;
		end else go <= 1'h0;
		linked = 1'h0;
		chk(padj, adj, "precision adjust");
		@(negedge sys_clk);
		stray <= str;
		#1;
		chk(busy, 1'h1, "busy");
		chk({sign_j, sign_k}, {j[59], k[59]}, "signs");
		chk({etj, etk}, {a[10], ~a[9:0], b[10], ~b[9:0]}, "true exponents");
		@(negedge sys_clk);
		stray <= 1'h0;
		#1;
		chk(enet.psum, ps, "pseudo sums");
		chk(enet.pcar, pc, "pseudo carries");
		chk(esum, t[12:0], "exponent sum");
		@(negedge sys_clk);
		rows <= r;
		low <= l;
		@(negedge sys_clk);
		rows <= ~r;
		low <= ~l;
		#1;
		chk(product_low, lo[23:0], "low product");
		if (chain) begin
			jin <= nj;
			kin <= nk;
			dblin <= nd;
			go <= 1'h1;
			linked = 1'h1;
		end
		@(negedge sys_clk);
		#1;
		chk({rv, busy}, 2'h2, "valid and busy");
		chk(left_shift, !(p[95] | f), "left shift");
		chk(coef, (p[95] | f) ? p[95:48] : p[94:47], "coefficient");
		chk(sections, {sc, se}, "sections");
		if (!chain) begin
			@(negedge sys_clk);
			#1;
			chk({rv, busy}, 2'h0, "valid pulse end");
		end
	endtask

	// Reset, then a plain double, a negative single chained to an unnormalized one
	initial begin
		rst = 1'h1;
		go = 1'h0;
		stray = 1'h0;
		dblin = 1'h0;
		jin = '0;
		kin = '0;
		rows = '0;
		low = '0;
		linked = 1'h0;
		repeat (8) @(negedge sys_clk);
		rst <= 1'h0;
		launch(60'h41F_8000_0000_0001, 60'h3E5_C000_0000_0000, 1'h1);
		run(60'h41F_8000_0000_0001, 60'h3E5_C000_0000_0000, 1'h1,
			{72'h40_0000_0000_0000_0000, 72'h40_0000_0000_0000_0001,
			72'h0F_0F0F_0F0F_0F0F_0F0F}, {24'hFFFFFF, 24'h000001}, 1'h0, 1'h0);
		launch(60'hA30_8123_4567_89AB, 60'h5FF_FFFF_0000_0000, 1'h0);
		nj = 60'h400_0000_0000_0001;
		nk = 60'hC00_8000_0000_0000;
		nd = 1'h1;
		run(60'hA30_8123_4567_89AB, 60'h5FF_FFFF_0000_0000, 1'h0,
			{72'h12_3456_789A_BCDE_F012, 72'h21_0FED_CBA9_8765_4321,
			72'h05_5555_5555_5555_5555}, {24'hABCDEF, 24'h123456}, 1'h1, 1'h0);
		run(nj, nk, nd, {72'h3F_FFFF_FFFF_FFFF_FFFF, 72'h00_0000_0000_0000_0001,
			72'h00_0000_0000_0000_0000}, {24'h800000, 24'h800000}, 1'h0, 1'h1);
		give_verdict;
	end
endmodule
`default_nettype wire
